// ### logic/fbc_host.v
// host controller: ahb-lite registers in, flash bank command sequences out
// Function
// RQ1: array reads work from power-up.
// RQ2: erase suspend: status in suspended sectors.
// RQ3: program suspend: array outside suspended sector.
// RQ4: host resets after timing flag or identification.
// RQ5: one reset returns to reading; address ignored.
// RQ6: reset between sequence writes aborts it.
// RQ7: reset ignored while program or erase runs.
// RQ8: reset leaves identification.
// RQ9: reset after timing flag restores read mode.
// RQ10: identification: two unlocks, bank address, command.
// RQ11: identification only from read, never while busy.
// RQ12: secured region: three-write entry, four-write exit.
// RQ13: serial number unreachable while busy.
// RQ14: secured mode blocks acceleration, bypass, identification.
// RQ15: program: two unlocks, setup, address and data.
// RQ16: program end returns to read; poll, toggle, ready show progress.
// RQ17: commands during programming are ignored.
// RQ18: secured and identification readout unavailable while busy.
// RQ19: programming never turns zero into one.
// RQ20: unlocks then 20h enter bypass; words take A0h and data.
// RQ21: bypass accepts only its program and its reset.
// RQ22: high voltage on protect pin enters bypass.
// RQ23: address on later falling strobe, data on first rising.
// RQ24: after wrong values or order the host writes reset.
// RQ25: unlock addresses and codes are named constants.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fbc_consts.vh"

module fbc_host (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  output wire [21:0] flash_addr,
  output wire [15:0] flash_dq_out,
  output wire        flash_dq_oe_n,
  input  wire [15:0] flash_dq_in,
  output wire        flash_ce_n,
  output wire        flash_we_n,
  output wire        flash_oe_n,
  output reg         flash_accel_hv,
  input  wire        flash_ready_busy_n
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_WR   = 3'h1;
  localparam [2:0] S_RD   = 3'h2;
  localparam [2:0] S_POLL = 3'h3;
  localparam [2:0] S_RST  = 3'h4;

  reg  [2:0]  state;
  reg  [3:0]  op;
  reg  [1:0]  step;
  reg  [2:0]  mode;
  reg  [21:0] addr_reg;
  reg  [15:0] wdata_reg;
  reg  [15:0] rdata_reg;
  reg  [15:0] prev;
  reg         have_prev;
  reg         tflag_seen;
  reg         refused;
  reg         tfail;
  reg         eng_start;
  reg         d_wr;
  reg  [2:0]  d_idx;
  reg  [37:0] seq_word;
  reg  [1:0]  last_step;
  reg         legal;
  wire        eng_done;
  wire [15:0] eng_rdata;
  wire        eng_wr;
  wire [21:0] eng_addr;
  wire [15:0] eng_wdata;
  wire        addr_ph;
  wire        cmd_wr;
  wire        acc_wr;
  wire [3:0]  new_op;

  // ----
  // ahb-lite slave
  // ----
  // zero wait states: every access ends in its first data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ph   = hsel & htrans[1] & hready;
  assign cmd_wr    = d_wr & (d_idx == `FBC_REG_CMD);
  assign acc_wr    = d_wr & (d_idx == `FBC_REG_ACCEL);
  assign new_op    = hwdata[3:0];

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      d_wr   <= 1'b0;
      d_idx  <= 3'h0;
      hrdata <= 32'h0000_0000;
    end else begin
      d_wr <= addr_ph & hwrite;
      if (addr_ph) begin
        d_idx <= haddr[4:2];
      end
      if (addr_ph & ~hwrite) begin
        case (haddr[4:2])
          `FBC_REG_CMD:    hrdata <= {28'h000_0000, op};
          `FBC_REG_ADDR:   hrdata <= {10'h000, addr_reg};
          `FBC_REG_WDATA:  hrdata <= {16'h0000, wdata_reg};
          `FBC_REG_RDATA:  hrdata <= {16'h0000, rdata_reg};
          `FBC_REG_STATUS: hrdata <= {25'h000_0000, mode, tfail, refused, flash_ready_busy_n, state != S_IDLE};
          `FBC_REG_ACCEL:  hrdata <= {31'h0000_0000, flash_accel_hv};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----
  // command legality and sequence table
  // ----
  always @* begin
    case (new_op)
      `FBC_OP_READ:     legal = 1'b1;
      // RQ21: bypass refuses others
      `FBC_OP_RESET:    legal = (mode != `FBC_MODE_BYP);
      // RQ11: identification from read only
      // RQ14: nothing extra while secured
      `FBC_OP_ID:       legal = (mode == `FBC_MODE_READ);
      `FBC_OP_SEC_IN:   legal = (mode == `FBC_MODE_READ);
      `FBC_OP_SEC_OUT:  legal = (mode == `FBC_MODE_SEC);
      `FBC_OP_PROG:     legal = (mode == `FBC_MODE_READ);
      `FBC_OP_BYP_IN:   legal = (mode == `FBC_MODE_READ);
      `FBC_OP_BYP_PROG: legal = (mode == `FBC_MODE_BYP);
      `FBC_OP_BYP_RST:  legal = (mode == `FBC_MODE_BYP) & ~flash_accel_hv;
      default:          legal = 1'b0;
    endcase
  end

  // RQ25: named unlock constants
  always @* begin
    last_step = 2'h2;
    seq_word  = {`FBC_UNLK1_ADDR, `FBC_UNLK1_DATA};
    if (step == 2'h1) begin
      seq_word = {`FBC_UNLK2_ADDR, `FBC_UNLK2_DATA};
    end
    case (op)
      // RQ5 RQ24: reset address ignored
      `FBC_OP_RESET: begin
        last_step = 2'h0;
        seq_word  = {addr_reg, `FBC_CODE_RESET};
      end
      // RQ10: bank address on third write
      `FBC_OP_ID: begin
        if (step == 2'h2) begin
          seq_word = {addr_reg, `FBC_CODE_ID};
        end
      end
      // RQ12: three-write entry, four-write exit
      `FBC_OP_SEC_IN: begin
        if (step == 2'h2) begin
          seq_word = {`FBC_UNLK1_ADDR, `FBC_CODE_SEC_IN};
        end
      end
      `FBC_OP_SEC_OUT: begin
        last_step = 2'h3;
        if (step == 2'h2) begin
          seq_word = {`FBC_UNLK1_ADDR, `FBC_CODE_SEC_X1};
        end else if (step == 2'h3) begin
          seq_word = {addr_reg, `FBC_CODE_ZERO};
        end
      end
      // RQ15: four-write program
      `FBC_OP_PROG: begin
        last_step = 2'h3;
        if (step == 2'h2) begin
          seq_word = {`FBC_UNLK1_ADDR, `FBC_CODE_PROG};
        end else if (step == 2'h3) begin
          seq_word = {addr_reg, wdata_reg};
        end
      end
      // RQ20: bypass entry code
      `FBC_OP_BYP_IN: begin
        if (step == 2'h2) begin
          seq_word = {`FBC_UNLK1_ADDR, `FBC_CODE_BYP};
        end
      end
      `FBC_OP_BYP_PROG: begin
        last_step = 2'h1;
        seq_word  = (step == 2'h0) ? {addr_reg, `FBC_CODE_PROG} : {addr_reg, wdata_reg};
      end
      `FBC_OP_BYP_RST: begin
        last_step = 2'h1;
        seq_word  = (step == 2'h0) ? {addr_reg, `FBC_CODE_BYP_X1} : {addr_reg, `FBC_CODE_ZERO};
      end
      default: begin
        last_step = 2'h0;
      end
    endcase
  end

  assign eng_wr    = (state == S_WR) | (state == S_RST) | (state == S_IDLE);
  assign eng_addr  = (state == S_WR) ? seq_word[37:16] : addr_reg;
  assign eng_wdata = (state == S_RST) ? `FBC_CODE_RESET : seq_word[15:0];

  // ----
  // sequencer and mode tracking
  // ----
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state          <= S_IDLE;
      op             <= `FBC_OP_READ;
      step           <= 2'h0;
      mode           <= `FBC_MODE_READ;
      addr_reg       <= 22'h00_0000;
      wdata_reg      <= 16'h0000;
      rdata_reg      <= 16'h0000;
      prev           <= 16'h0000;
      have_prev      <= 1'b0;
      tflag_seen     <= 1'b0;
      refused        <= 1'b0;
      tfail          <= 1'b0;
      eng_start      <= 1'b0;
      flash_accel_hv <= 1'b0;
    end else begin
      eng_start <= 1'b0;
      if (d_wr & (d_idx == `FBC_REG_ADDR)) begin
        addr_reg <= hwdata[21:0];
      end
      if (d_wr & (d_idx == `FBC_REG_WDATA)) begin
        wdata_reg <= hwdata[15:0];
      end
      // RQ22: accel only in read mode
      if (acc_wr) begin
        if ((state == S_IDLE) & hwdata[0] & ~flash_accel_hv & (mode == `FBC_MODE_READ)) begin
          flash_accel_hv <= 1'b1;
          mode           <= `FBC_MODE_BYP;
        end else if ((state == S_IDLE) & ~hwdata[0] & flash_accel_hv) begin
          flash_accel_hv <= 1'b0;
          mode           <= `FBC_MODE_READ;
        end else if (hwdata[0] != flash_accel_hv) begin
          refused <= 1'b1;
        end
      end
      case (state)
        S_IDLE: begin
          if (cmd_wr) begin
            if (legal & ~acc_wr) begin
              op         <= new_op;
              step       <= 2'h0;
              refused    <= 1'b0;
              tfail      <= 1'b0;
              have_prev  <= 1'b0;
              tflag_seen <= 1'b0;
              eng_start  <= 1'b1;
              state      <= (new_op == `FBC_OP_READ) ? S_RD : S_WR;
            end else begin
              refused <= 1'b1;
            end
          end
        end
        S_WR: begin
          if (cmd_wr) begin
            refused <= 1'b1;
          end
          if (eng_done) begin
            if (step == last_step) begin
              state <= S_IDLE;
              case (op)
                // RQ8: reset leaves identification
                // RQ12: secured stays mapped
                `FBC_OP_RESET:   mode <= (mode == `FBC_MODE_SEC) ? `FBC_MODE_SEC : `FBC_MODE_READ;
                `FBC_OP_ID:      mode <= `FBC_MODE_ID;
                `FBC_OP_SEC_IN:  mode <= `FBC_MODE_SEC;
                `FBC_OP_SEC_OUT: mode <= `FBC_MODE_READ;
                `FBC_OP_BYP_IN:  mode <= `FBC_MODE_BYP;
                `FBC_OP_BYP_RST: mode <= `FBC_MODE_READ;
                default:         mode <= mode;
              endcase
              if ((op == `FBC_OP_PROG) | (op == `FBC_OP_BYP_PROG)) begin
                eng_start <= 1'b1;
                state     <= S_POLL;
              end
            end else begin
              step      <= step + 2'h1;
              eng_start <= 1'b1;
            end
          end
        end
        S_RD: begin
          if (cmd_wr) begin
            refused <= 1'b1;
          end
          if (eng_done) begin
            rdata_reg <= eng_rdata;
            state     <= S_IDLE;
          end
        end
        // RQ16: toggle poll until stable
        S_POLL: begin
          if (cmd_wr) begin
            refused <= 1'b1;
          end
          if (eng_done) begin
            prev      <= eng_rdata;
            have_prev <= 1'b1;
            eng_start <= 1'b1;
            if (have_prev & (eng_rdata[6] == prev[6])) begin
              rdata_reg <= eng_rdata;
              eng_start <= 1'b0;
              state     <= S_IDLE;
            end else if (have_prev & eng_rdata[5]) begin
              // RQ4: timing flag needs reset
              // flag may rise as the program ends, so one more read is compared first
              if (tflag_seen) begin
                state <= S_RST;
              end
              tflag_seen <= 1'b1;
            end
          end
        end
        S_RST: begin
          if (cmd_wr) begin
            refused <= 1'b1;
          end
          if (eng_done) begin
            tfail <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  fbc_cycle u_cycle (
    .mclk          (mclk),
    .arst_n        (arst_n),
    .start         (eng_start),
    .wr            (eng_wr),
    .addr          (eng_addr),
    .wdata         (eng_wdata),
    .done          (eng_done),
    .rdata         (eng_rdata),
    .flash_addr    (flash_addr),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_dq_in   (flash_dq_in),
    .flash_ce_n    (flash_ce_n),
    .flash_we_n    (flash_we_n),
    .flash_oe_n    (flash_oe_n)
  );

endmodule

// ### logic/fbc_consts.vh
// constants of the flash bank command host: offsets, codes, timing
`ifndef FBC_CONSTS_VH
`define FBC_CONSTS_VH

// ----
// register word offsets
// ----
`define FBC_REG_CMD    3'h0
`define FBC_REG_ADDR   3'h1
`define FBC_REG_WDATA  3'h2
`define FBC_REG_RDATA  3'h3
`define FBC_REG_STATUS 3'h4
`define FBC_REG_ACCEL  3'h5

// ----
// status field positions
// ----
`define FBC_ST_BUSY    0
`define FBC_ST_RDY     1
`define FBC_ST_REFUSED 2
`define FBC_ST_TFAIL   3
`define FBC_ST_MODE_LO 4

// ----
// host commands (cmd register bits 3:0)
// ----
`define FBC_OP_READ     4'h0
`define FBC_OP_RESET    4'h1
`define FBC_OP_ID       4'h2
`define FBC_OP_SEC_IN   4'h3
`define FBC_OP_SEC_OUT  4'h4
`define FBC_OP_PROG     4'h5
`define FBC_OP_BYP_IN   4'h6
`define FBC_OP_BYP_PROG 4'h7
`define FBC_OP_BYP_RST  4'h8

// ----
// tracked device modes
// ----
`define FBC_MODE_READ 3'h0
`define FBC_MODE_ID   3'h1
`define FBC_MODE_SEC  3'h2
`define FBC_MODE_BYP  3'h3

// ----
// unlock addresses and command codes
// ----
`define FBC_UNLK1_ADDR  22'h00_0555
`define FBC_UNLK2_ADDR  22'h00_02aa
`define FBC_UNLK1_DATA  16'h00aa
`define FBC_UNLK2_DATA  16'h0055
`define FBC_CODE_RESET  16'h00f0
`define FBC_CODE_ID     16'h0090
`define FBC_CODE_SEC_IN 16'h0088
`define FBC_CODE_SEC_X1 16'h0090
`define FBC_CODE_ZERO   16'h0000
`define FBC_CODE_PROG   16'h00a0
`define FBC_CODE_BYP    16'h0020
`define FBC_CODE_BYP_X1 16'h0090

// ----
// strobe timing
// ----
`define FBC_CLK_NS   20
`define FBC_T_SU_NS  20
`define FBC_T_WP_NS  35
`define FBC_T_RD_NS  70
`define FBC_T_HD_NS  20
`define FBC_SU_CYC   ((`FBC_T_SU_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_WP_CYC   ((`FBC_T_WP_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_RD_CYC   ((`FBC_T_RD_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_HD_CYC   ((`FBC_T_HD_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)

`endif

// ### logic/fbc_cycle.v
// one asynchronous flash bus cycle, read or write, on the device pins
`timescale 1ns/1ps
`include "fbc_consts.vh"

module fbc_cycle (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        start,
  input  wire        wr,
  input  wire [21:0] addr,
  input  wire [15:0] wdata,
  output reg         done,
  output reg  [15:0] rdata,
  output reg  [21:0] flash_addr,
  output reg  [15:0] flash_dq_out,
  output reg         flash_dq_oe_n,
  input  wire [15:0] flash_dq_in,
  output reg         flash_ce_n,
  output reg         flash_we_n,
  output reg         flash_oe_n
);

  localparam [31:0] SU_FULL = `FBC_SU_CYC;
  localparam [31:0] WP_FULL = `FBC_WP_CYC;
  localparam [31:0] RD_FULL = `FBC_RD_CYC;
  localparam [31:0] HD_FULL = `FBC_HD_CYC;
  localparam [3:0]  SU_CYC  = SU_FULL[3:0];
  localparam [3:0]  WP_CYC  = WP_FULL[3:0];
  localparam [3:0]  RD_CYC  = RD_FULL[3:0];
  localparam [3:0]  HD_CYC  = HD_FULL[3:0];

  localparam [1:0] C_IDLE  = 2'h0;
  localparam [1:0] C_SETUP = 2'h1;
  localparam [1:0] C_STRB  = 2'h2;
  localparam [1:0] C_HOLD  = 2'h3;

  reg [1:0] state;
  reg [3:0] cnt;
  reg       is_wr;

  // ----
  // strobe sequencer
  // ----
  // RQ23: address latch order
  // ce_n leads and trails, so we_n edges latch address and data
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state         <= C_IDLE;
      cnt           <= 4'h0;
      is_wr         <= 1'b0;
      done          <= 1'b0;
      rdata         <= 16'h0000;
      flash_addr    <= 22'h00_0000;
      flash_dq_out  <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state)
        C_IDLE: begin
          if (start) begin
            is_wr         <= wr;
            flash_addr    <= addr;
            flash_dq_out  <= wdata;
            flash_dq_oe_n <= ~wr;
            flash_ce_n    <= 1'b0;
            cnt           <= SU_CYC;
            state         <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (cnt == 4'h1) begin
            flash_we_n <= ~is_wr;
            flash_oe_n <= is_wr;
            cnt        <= is_wr ? WP_CYC : RD_CYC;
            state      <= C_STRB;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        C_STRB: begin
          if (cnt == 4'h1) begin
            if (!is_wr) begin
              rdata <= flash_dq_in;
            end
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt        <= HD_CYC;
            state      <= C_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        C_HOLD: begin
          if (cnt == 4'h1) begin
            flash_ce_n    <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            done          <= 1'b1;
            state         <= C_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          state <= C_IDLE;
        end
      endcase
    end
  end

endmodule

// ### tb/fbc_host_asserts.sv
// checker for the flash host strobes and bus answers
`timescale 1ns/1ps
module fbc_host_asserts (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe_n,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_ready_busy_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ----
  // strobe shapes
  // ----
  sequence s_wr_pulse; !flash_we_n [*2] ##1 flash_we_n; endsequence
  sequence s_rd_pulse; !flash_oe_n [*4] ##1 flash_oe_n; endsequence
  sequence s_release; !flash_ce_n ##1 flash_ce_n; endsequence

  property p_bus_okay; hreadyout && !hresp; endproperty
  property p_wr_width; $fell(flash_we_n) |-> s_wr_pulse; endproperty
  property p_rd_width; $fell(flash_oe_n) |-> s_rd_pulse; endproperty
  property p_ce_lead; $fell(flash_we_n) || $fell(flash_oe_n) |-> !$past(flash_ce_n); endproperty
  property p_ce_trail; $rose(flash_we_n) || $rose(flash_oe_n) |-> s_release; endproperty
  property p_wr_hold;
    !flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && $stable(flash_addr) && $stable(flash_dq_out);
  endproperty
  property p_no_fight; !flash_oe_n |-> flash_dq_oe_n && flash_we_n; endproperty
  // only a reset may reach a busy bank
  property p_busy_quiet; !flash_we_n && !flash_ready_busy_n |-> flash_dq_out == 16'h00f0; endproperty

  // ----
  // assertions
  // ----
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not okay");
  a_wr_width: assert property (p_wr_width) else $error("write pulse width wrong");
  a_rd_width: assert property (p_rd_width) else $error("read pulse width wrong");
  a_ce_lead: assert property (p_ce_lead) else $error("strobe without chip enable");
  a_ce_trail: assert property (p_ce_trail) else $error("chip enable release late");
  a_wr_hold: assert property (p_wr_hold) else $error("write cycle unstable");
  a_no_fight: assert property (p_no_fight) else $error("data bus contention");
  a_busy_quiet: assert property (p_busy_quiet) else $error("command while busy");
endmodule

bind fbc_host fbc_host_asserts u_chk (
  .mclk(mclk), .arst_n(arst_n), .hreadyout(hreadyout), .hresp(hresp), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_ready_busy_n(flash_ready_busy_n));

// ### tb/fbc_flash_model.sv
// behavioural flash device: command decoder, array, id and secured words
`timescale 1ns/1ps
module fbc_flash_model #(
  parameter logic [15:0] ID_WORD = 16'h1234, // arbitrary value
  parameter logic [15:0] SN_BASE = 16'h5a00  // arbitrary value
) (
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_accel_hv,
  input  wire logic        inj_tfail,
  output wire logic [15:0] dq,
  output wire logic        ready_busy_n
);
  localparam int RD = 0, ID = 1, SEC = 2, BYP = 3;
  logic [15:0] mem [int];
  logic [15:0] val = 16'h0;
  logic [15:0] pd = 16'h0;
  logic [21:0] la;
  int          mode = RD;
  int          ph = 0;
  int          bcnt = 0;
  logic        busy = 0;
  logic        tfe = 0;
  logic        tog = 0;
  logic        got = 0;
  wire         wr = !flash_we_n && !flash_ce_n;
  wire         rd = !flash_oe_n && !flash_ce_n;

  // released bus shows the inverse, never a stale copy
  assign dq = rd ? val : ~val;
  assign ready_busy_n = !busy;

  // no suspended sector: array, erased reads ones
  function automatic logic [15:0] arr(input logic [21:0] a);
    arr = mem.exists(a) ? mem[a] : 16'hffff;
  endfunction

  task automatic decode(input logic [21:0] a, input logic [15:0] d);
    // busy hears a reset only after a timing fault
    if (busy) begin
      if (tfe && d == 16'h00f0) busy = 0;
    end else if (ph == 3) begin
      // last write starts program, zeros stay zero
      mem[a] = arr(a) & d;
      pd = d;
      tfe = inj_tfail;
      bcnt = 3;
      busy = 1;
      ph = 0;
    end else if (d == 16'h00f0 && mode != BYP) begin
      // reset aborts a sequence and leaves id
      ph = 0;
      if (mode == ID) mode = RD;
    end else case (ph)
      // bypass knows only its program and its reset
      0: if (mode == BYP) ph = d == 16'h00a0 ? 3 : d == 16'h0090 ? 5 : 0;
         else ph = (a == 22'h00_0555 && d == 16'h00aa) ? 1 : 0;
      1: ph = (a == 22'h00_02aa && d == 16'h0055) ? 2 : 0;
      2: begin
        ph = 0;
        case (d)
          16'h0090: if (mode == SEC) ph = 4; else mode = ID;
          16'h0088: mode = SEC;
          16'h00a0: ph = 3;
          16'h0020: if (mode != SEC) mode = BYP;
          default: ;
        endcase
      end
      // closing zero write of both exits
      default: begin
        if (d == 16'h0000) mode = RD;
        ph = 0;
      end
    endcase
  endtask

  // address on the later falling strobe
  always @(posedge wr) begin
    la = flash_addr;
    got = 1;
  end
  // data on the first rising strobe
  always @(negedge wr) if (got) begin
    got = 0;
    decode(la, flash_dq_out);
  end

  // busy reads give toggling status only
  always @(posedge rd) begin
    if (busy) begin
      tog = ~tog;
      val = {8'h00, ~pd[7], tog, tfe, 5'h00};
      if (!tfe) bcnt--;
      if (bcnt == 0) busy = 0;
    end else
      val = mode == ID ? ID_WORD : mode == SEC ? SN_BASE + 16'(flash_addr[2:0]) : arr(flash_addr);
  end

  // high voltage jumps straight to bypass
  always @(posedge flash_accel_hv) mode = BYP;
  always @(negedge flash_accel_hv) mode = RD;
endmodule

// ### tb/fbc_host_tb.sv
// testbench for the flash bank command host
`timescale 1ns/1ps
module fbc_host_tb;
  localparam logic [15:0] ID_W = 16'h1234; // arbitrary value
  localparam logic [15:0] SN_B = 16'h5a00; // arbitrary value
  logic        mclk = 0;
  logic        arst_n = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        inj = 0;
  logic        dp_chk = 0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire         hreadyout, hresp, ce_n, we_n, oe_n, dq_oe_n, accel, rbn;
  wire  [31:0] hrdata;
  wire  [21:0] fa;
  wire  [15:0] dq_out, dq_m, dq_in;
  int          n_fail = 0;
  int          compares = 0;
  int          i;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  logic [21:0] ra, rb;
  logic [15:0] d1, d2;

  assign dq_in = !dq_oe_n ? dq_out : dq_m;

  fbc_host DUT (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n),
    .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_accel_hv(accel), .flash_ready_busy_n(rbn));
  fbc_flash_model #(.ID_WORD(ID_W), .SN_BASE(SN_B)) flash (
    .flash_addr(fa), .flash_dq_out(dq_out), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_accel_hv(accel), .inj_tfail(inj), .dq(dq_m), .ready_busy_n(rbn));

  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  always @(posedge mclk) if (dp_chk) chk(nm_q.pop_front(), hrdata, exp_q.pop_front());

  task automatic ahb(input logic [31:0] a, d, input logic w, c, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    dp_chk <= c;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    r = hrdata;
    dp_chk <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    ahb(a, d, 1'b1, 1'b0, r);
  endtask

  task automatic ex(input logic [31:0] a, exp, input string nm);
    logic [31:0] r;
    exp_q.push_back(exp);
    nm_q.push_back(nm);
    ahb(a, 32'h0, 1'b0, 1'b1, r);
  endtask

  task automatic op(input logic [3:0] o, input logic [21:0] a = 22'h0, input logic [15:0] d = 16'h0);
    logic [31:0] r;
    int k;
    wr(32'h04, {10'h0, a});
    wr(32'h08, {16'h0, d});
    wr(32'h00, {28'h0, o});
    r = 32'h1;
    k = 0;
    // poll until idle, bounded
    while (r[0] === 1'b1 && k < 3000) begin
      ahb(32'h10, 32'h0, 1'b0, 1'b0, r);
      k++;
    end
    if (k == 3000) chk("busy wait", r, 32'h0);
  endtask

  function automatic logic [31:0] st(input int m, rf, tf);
    st = {25'h0, 3'(m), 1'(tf), 1'(rf), 2'b10};
  endfunction

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----
  // clock, watchdog, tests
  // ----
  initial forever #10 mclk = ~mclk;

  initial begin
    #1_000_000;
    n_fail++;
    end_sim();
  end

  initial begin
    d1 = 16'($urandom(89876));
    d2 = 16'($urandom());
    ra = {2'b01, 20'($urandom())};
    rb = {2'b10, 20'($urandom())};
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    ex(32'h10, st(0, 0, 0), "status after reset");
    op(4'h0, ra);
    ex(32'h0c, 32'h0000_ffff, "erased word");
    ex(32'h04, {10'h0, ra}, "addr reg");
    ex(32'h18, 32'h0, "unmapped");
    $display("power-up test done");
    op(4'h5, ra, d1);
    op(4'h0, ra);
    ex(32'h0c, {16'h0, d1}, "programmed word");
    op(4'h5, ra, d2);
    op(4'h0, ra);
    ex(32'h0c, {16'h0, d1 & d2}, "zeros kept");
    $display("program test done");
    op(4'h2, ra);
    ex(32'h10, st(1, 0, 0), "id mode");
    repeat (2) begin
      op(4'h0, rb);
      ex(32'h0c, {16'h0, ID_W}, "id word");
    end
    op(4'h1, 22'($urandom()));
    ex(32'h10, st(0, 0, 0), "reset from id");
    op(4'h0, ra);
    ex(32'h0c, {16'h0, d1 & d2}, "array after id");
    $display("id test done");
    op(4'h3);
    ex(32'h10, st(2, 0, 0), "secure mode");
    op(4'h0, 22'h5);
    ex(32'h0c, {16'h0, SN_B + 16'h5}, "serial word");
    op(4'h1);
    ex(32'h10, st(2, 0, 0), "reset in secure");
    op(4'h6);
    ex(32'h10, st(2, 1, 0), "bypass in secure");
    op(4'h2);
    ex(32'h10, st(2, 1, 0), "id in secure");
    op(4'h4, ra);
    ex(32'h10, st(0, 0, 0), "secure exit");
    op(4'h0, ra);
    ex(32'h0c, {16'h0, d1 & d2}, "array after exit");
    $display("secure test done");
    for (i = 0; i < 2; i++) begin
      if (i == 1) wr(32'h14, 32'h1);
      else op(4'h6);
      ex(32'h10, st(3, 0, 0), "bypass mode");
      chk("accel pin", {31'h0, accel}, 32'(i));
      op(4'h7, rb + 22'(i), d2);
      op(4'h0, rb + 22'(i));
      ex(32'h0c, {16'h0, d2}, "bypass word");
      if (i == 0) begin
        op(4'h1);
        ex(32'h10, st(3, 1, 0), "reset in bypass");
        op(4'h8);
      end else wr(32'h14, 32'h0);
      ex(32'h10, st(0, 0, 0), "bypass left");
    end
    $display("bypass test done");
    inj <= 1'b1;
    op(4'h5, rb + 22'h2, d1);
    ex(32'h10, st(0, 0, 1), "timing fault");
    inj <= 1'b0;
    op(4'h0, rb + 22'h2);
    ex(32'h0c, {16'h0, d1}, "read after fault");
    $display("timing fault test done");
    @(posedge mclk);
    end_sim();
  end
endmodule
